// [sim/sram_ctl_props.sv]
// Purpose: Pin-level checks of the memory controller
// Assumes: Bound to sram_ctl, one clock domain
// Notes:   Write pulse checked as three or four low cycles
`timescale 1ns/1ns
module sram_ctl_props
	import sram_ctl_pkg::*;
(
	// Clock and reset
	input wire logic                    SYS_CLK_I,
	input wire logic                    RESET_I,
	// User request side
	input wire logic                    REQ_VALID_I,
	input wire sram_ctl_pkg::mem_req_t  REQ_I,
	input wire logic                    REQ_READY_O,
	input wire logic                    RD_VALID_O,
	input wire logic [31:0]             RD_DATA_O,
	// Supply state
	input wire logic                    RETENTION_EXIT_I,
	input wire logic                    MEM_READY_O,
	// Memory pins
	input wire sram_ctl_pkg::mem_pins_t MEM_O,
	input wire logic [31:0]             DATA_PINS_I
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);
	wire cs_n = MEM_O.chip_select_n_first;
	sequence s_wr_low; !MEM_O.write_en_n [*3]; endsequence
	sequence s_wr_end; MEM_O.write_en_n && cs_n; endsequence
	property p_sel_eq; cs_n == MEM_O.chip_select_n_second && cs_n == MEM_O.chip_select_n_third; endproperty
	property p_rd_nodrv; !MEM_O.out_en_n |-> MEM_O.data_pins_oe == 32'h0; endproperty
	property p_wr_drv; !cs_n && !MEM_O.write_en_n |-> MEM_O.data_pins_oe == 32'hffffffff; endproperty
	property p_addr_first; $fell(cs_n) |-> $stable(MEM_O.addr); endproperty
	property p_wr_pulse; $fell(MEM_O.write_en_n) |-> s_wr_low ##[1:2] s_wr_end; endproperty
	property p_wr_end; $rose(MEM_O.write_en_n) |-> $rose(cs_n) && MEM_O.data_pins_oe == 32'hffffffff; endproperty
	property p_rd_answer; $fell(MEM_O.out_en_n) |-> ##3 RD_VALID_O; endproperty
	property p_wait; !MEM_READY_O |-> cs_n && MEM_O.write_en_n; endproperty
	a_sel_eq: assert property (p_sel_eq) else $error("selects differ");
	a_rd_nodrv: assert property (p_rd_nodrv) else $error("driving during read");
	a_wr_drv: assert property (p_wr_drv) else $error("write data not driven");
	a_addr_first: assert property (p_addr_first) else $error("address moved at select");
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse wrong");
	a_wr_end: assert property (p_wr_end) else $error("write end wrong");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_wait: assert property (p_wait) else $error("access before ready");
endmodule : sram_ctl_props
bind sram_ctl sram_ctl_props sram_ctl_props_inst (
	.SYS_CLK_I        (SYS_CLK_I),
	.RESET_I          (RESET_I),
	.REQ_VALID_I      (REQ_VALID_I),
	.REQ_I            (REQ_I),
	.REQ_READY_O      (REQ_READY_O),
	.RD_VALID_O       (RD_VALID_O),
	.RD_DATA_O        (RD_DATA_O),
	.RETENTION_EXIT_I (RETENTION_EXIT_I),
	.MEM_READY_O      (MEM_READY_O),
	.MEM_O            (MEM_O),
	.DATA_PINS_I      (DATA_PINS_I)
);

// [sim/sram_model.sv]
// Purpose: Behavioural static memory at the controller pins
// Assumes: No pull on data lines; a lane it does not drive shows inverted data
// Notes:   Bytes commit when the write overlap ends
`timescale 1ns/1ns
module sram_model
	import sram_ctl_pkg::*;
(
	input  sram_ctl_pkg::mem_pins_t pins_i,
	input  wire logic [31:0]        bus_i,
	output logic [31:0]             drive_o
);
	logic [31:0] mem [logic [18:0]];
	logic [31:0] wd, q, mask;
	logic [3:0]  wbe;
	logic [18:0] wa;
	// Selected only while all three selects are low
	wire sel = !pins_i.chip_select_n_first && !pins_i.chip_select_n_second && !pins_i.chip_select_n_third;
	wire wr  = sel && !pins_i.write_en_n;
	wire rd  = sel && !pins_i.out_en_n && pins_i.write_en_n;
	// Capture the write while the overlap lasts; the end edge commits it
	always @* begin
		if (wr) begin
			{wa, wbe, wd} = {pins_i.addr, pins_i.byte_en_n, bus_i};
		end
	end
	always @(negedge wr) begin
		for (int i = 0; i < 4; i++) begin
			if (wbe[i] === 1'b0) mem[wa][8*i+:8] = wd[8*i+:8];
		end
	end
	// Enabled lanes drive data; the others toggle away from it, never hold it
	always @* begin
		q = mem.exists(pins_i.addr) ? mem[pins_i.addr] : 32'h0;
		for (int i = 0; i < 4; i++) begin
			mask[8*i+:8] = {8{rd && !pins_i.byte_en_n[i]}};
		end
		drive_o = q ^ ~mask;
	end
endmodule : sram_model

// [sim/tb.sv]
// Purpose: Self-checking bench for the static memory controller
// Assumes: Shortened power-up and recovery counts
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ns
module tb;
	import sram_ctl_pkg::*;
	localparam int PU = 8;
	localparam int RC = 5;
	logic        clk, rst, valid, rexit, ready, rdv, mready;
	mem_req_t    req;
	mem_pins_t   pins;
	logic [31:0] rdata, drive, bus;
	logic [31:0] ref_mem [logic [18:0]];
	int          num_errors, checks_done, n;
	// Pin level from whichever side drives each bit
	assign bus = (pins.data_pins_oe & pins.data_pins_out) | (~pins.data_pins_oe & drive);
	sram_ctl #(.POWER_UP_CYCLES(PU), .RETENTION_CYCLES(RC)) sram_ctl_inst (.SYS_CLK_I(clk), .RESET_I(rst),
		.REQ_VALID_I(valid), .REQ_I(req), .REQ_READY_O(ready), .RD_VALID_O(rdv), .RD_DATA_O(rdata),
		.RETENTION_EXIT_I(rexit), .MEM_READY_O(mready), .MEM_O(pins), .DATA_PINS_I(bus));
	sram_model sram_model_inst (.pins_i(pins), .bus_i(bus), .drive_o(drive));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	// Bounded count of cycles until the memory is usable
	task automatic wait_ready(output int cyc);
		for (cyc = 0; mready !== 1'b1 && cyc < 100; cyc++) @(negedge clk);
	endtask : wait_ready
	// Hold the request until taken; a read also waits for its answer
	task automatic access(input logic wr, input logic [18:0] a, input logic [31:0] d, input logic [3:0] ln);
		@(negedge clk);
		req = '{wr, a, d, ln};
		valid = 1'b1;
		for (n = 0; ready !== 1'b1 && n < 50; n++) @(negedge clk);
		check(ready, 32'h1);
		@(negedge clk);
		valid = 1'b0;
		for (n = 0; !wr && rdv !== 1'b1 && n < 50; n++) @(negedge clk);
		if (!wr) check(rdv, 32'h1);
	endtask : access
	task automatic wr_word(input logic [18:0] a, input logic [31:0] d, input logic [3:0] ln);
		access(1'b1, a, d, ln);
		for (int i = 0; i < 4; i++) if (ln[i]) ref_mem[a][8*i+:8] = d[8*i+:8];
	endtask : wr_word
	// Lanes not enabled come back as zero
	task automatic rd_check(input logic [18:0] a, input logic [3:0] ln);
		logic [31:0] m;
		for (int i = 0; i < 4; i++) m[8*i+:8] = {8{ln[i]}};
		access(1'b0, a, 32'h0, ln);
		check(rdata, ref_mem[a] & m);
	endtask : rd_check
	// Reset leaves the first select, both strobes and the data drive released and the wait running
	task automatic t_power();
		int cyc;
		check(ready, 32'h0);
		check(mready, 32'h0);
		check({29'h0, pins.chip_select_n_first, pins.write_en_n, pins.out_en_n}, 32'h7);
		check(pins.data_pins_oe, 32'h0);
		wait_ready(cyc);
		check(mready, 32'h1);
		check(cyc >= PU, 32'h1);
	endtask : t_power
	// Lane writes back to back with reads, at both address ends
	task automatic t_lanes();
		wr_word(19'h7ffff, 32'h11223344, 4'hf);
		wr_word(19'h00000, 32'ha5a5a5a5, 4'hf);
		for (int i = 0; i < 4; i++) begin
			wr_word(19'h7ffff, 32'hcafef00d, 4'h1 << i);
			rd_check(19'h7ffff, 4'hf);
			rd_check(19'h7ffff, 4'h1 << i);
		end
		rd_check(19'h00000, 4'h6);
	endtask : t_lanes
	task automatic t_retention();
		int cyc;
		@(negedge clk);
		rexit = 1'b1;
		@(negedge clk);
		rexit = 1'b0;
		check(mready, 32'h0);
		check(ready, 32'h0);
		wait_ready(cyc);
		check(mready, 32'h1);
		check(cyc + 1 >= RC, 32'h1);
		rd_check(19'h00000, 4'hf);
	endtask : t_retention
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rst, valid, rexit, req} = {1'b1, 2'b00, 56'h0};
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_power();
		t_lanes();
		t_retention();
		stop_test();
	end
	// Whole run needs well under a microsecond
	initial begin
		#20000;
		num_errors++;
		stop_test();
	end
endmodule : tb

// [src/sram_ctl.sv]
// Purpose: Host-side controller driving an asynchronous 32-bit static memory
// Assumes: Inputs synchronous to SYS_CLK_I; RESET_I marks supply just valid
// Notes:   One access at a time; strobes timed by counters, not pins
//          Retention exit aborts any access in flight, with no answer
`timescale 1ns/1ns

// Notes on behaviour
// - Write ends at strobe end, data held
// - Wait power-up interval before first access
// - Power-up interval at least one millisecond
// - Write pulse covers float plus setup
// - Retention recovery waits one hundred microseconds
// - Address valid before selects go low
module sram_ctl
	import sram_ctl_pkg::*;
#(
	parameter int POWER_UP_CYCLES  = sram_ctl_pkg::POWER_UP_CYC,
	parameter int RETENTION_CYCLES = sram_ctl_pkg::RETENTION_CYC
) (
	// Clock and reset
	input  wire logic                          SYS_CLK_I,
	input  wire logic                          RESET_I,
	// User request side
	input  wire logic                          REQ_VALID_I,
	input  wire sram_ctl_pkg::mem_req_t        REQ_I,
	output logic                               REQ_READY_O,
	output logic                               RD_VALID_O,
	output logic [sram_ctl_pkg::DATA_W-1:0]    RD_DATA_O,
	// Supply state: retention ended, restart recovery wait
	input  wire logic                          RETENTION_EXIT_I,
	output logic                               MEM_READY_O,
	// Memory pins
	output sram_ctl_pkg::mem_pins_t            MEM_O,
	input  wire logic [sram_ctl_pkg::DATA_W-1:0] DATA_PINS_I
);
	import sram_ctl_pkg::*;

	// Elaboration checks: the wait counter must hold every load value
	if (POWER_UP_CYCLES < 1 || POWER_UP_CYCLES >= (1 << WAIT_W)) begin : g_bad_power_up
		$error("POWER_UP_CYCLES out of range");
	end
	if (RETENTION_CYCLES < 1 || RETENTION_CYCLES >= (1 << WAIT_W)) begin : g_bad_retention
		$error("RETENTION_CYCLES out of range");
	end
	// Strobe counts must fit the step counter as well
	if (WRITE_PULSE_CYC < 1 || WRITE_PULSE_CYC > (1 << STEP_W)) begin : g_bad_write_pulse
		$error("WRITE_PULSE_CYC does not fit the step counter");
	end
	if (READ_CYC < 1 || READ_CYC > (1 << STEP_W)) begin : g_bad_read_strobe
		$error("READ_CYC does not fit the step counter");
	end
	// Byte lanes are eight bits wide
	if (DATA_W != 8 * LANES) begin : g_bad_lanes
		$error("DATA_W must be eight bits per lane");
	end

	// Sequencer phases
	typedef enum logic [2:0] {
		ST_POWER,
		ST_IDLE,
		ST_RD_ADDR,
		ST_RD_STROBE,
		ST_WR_ADDR,
		ST_WR_STROBE,
		ST_WR_HOLD
	} phase_t;

	// Whole state of the controller in one register
	typedef struct packed {
		phase_t                phase;
		logic [WAIT_W-1:0]     wait_cnt;
		logic [STEP_W-1:0]     step;
		mem_req_t              req;
		logic                  sel;
		logic                  oe;
		logic                  we;
		logic                  drive;
		logic                  rd_valid;
		logic [DATA_W-1:0]     rd_data;
	} state_t;

	// Registered state and its next value
	state_t st_ff;
	state_t nxt_st;

	// Counter loads; counts run down to zero, so each is one less than its span
	localparam logic [WAIT_W-1:0] PU_LOAD  = WAIT_W'(POWER_UP_CYCLES - 1);
	localparam logic [WAIT_W-1:0] RET_LOAD = WAIT_W'(RETENTION_CYCLES - 1);
	localparam logic [STEP_W-1:0] WR_LOAD  = STEP_W'(WRITE_PULSE_CYC - 1);
	localparam logic [STEP_W-1:0] RD_LOAD  = STEP_W'(READ_CYC - 1);

	// Handshake and strobe decode shared by the sequencer
	logic take_req;
	logic step_done;
	assign take_req  = REQ_VALID_I && REQ_READY_O;
	assign step_done = (st_ff.step == '0);

	// Read:  take, address cycle, READ_CYC strobe cycles, data caught on the last edge
	// Write: take, address cycle, WRITE_PULSE_CYC strobe cycles, one data hold cycle
	// Strobe counts are minimums for this clock; a faster clock must recount them
	// Sequencer: one access at a time, address always set a cycle ahead
	always_comb begin
		nxt_st          = st_ff;
		nxt_st.rd_valid = 1'b0;
		case (st_ff.phase)
			ST_POWER: begin
				// No access until the supply wait has run out
				if (st_ff.wait_cnt == '0)
					nxt_st.phase = ST_IDLE;
				else
					nxt_st.wait_cnt = st_ff.wait_cnt - 1'b1;
			end
			ST_IDLE: begin
				// Requests outside idle are refused, one access in flight
				if (take_req) begin
					nxt_st.req   = REQ_I;
					nxt_st.phase = REQ_I.write ? ST_WR_ADDR : ST_RD_ADDR;
				end
			end
			ST_RD_ADDR: begin
				// Address already stable, now select and enable outputs
				nxt_st.sel   = 1'b1;
				nxt_st.oe    = 1'b1;
				nxt_st.step  = RD_LOAD;
				nxt_st.phase = ST_RD_STROBE;
			end
			ST_RD_STROBE: begin
				if (step_done) begin
					// Capture only enabled lanes, others read as zero
					for (int i = 0; i < LANES; i++)
						nxt_st.rd_data[8*i +: 8] = st_ff.req.lane_en[i] ? DATA_PINS_I[8*i +: 8] : 8'h00;
					nxt_st.rd_valid = 1'b1;
					nxt_st.sel      = 1'b0;
					nxt_st.oe       = 1'b0;
					nxt_st.phase    = ST_IDLE;
				end else begin
					// Access time still running
					nxt_st.step = st_ff.step - 1'b1;
				end
			end
			ST_WR_ADDR: begin
				// Output enable stays high so memory never fights us
				nxt_st.sel   = 1'b1;
				nxt_st.we    = 1'b1;
				// Data on the pins from the first strobe cycle on
				nxt_st.drive = 1'b1;
				nxt_st.step  = WR_LOAD;
				nxt_st.phase = ST_WR_STROBE;
			end
			ST_WR_STROBE: begin
				// Write enable stays low until the count runs out
				if (step_done) begin
					// Select and write end together; memory keeps pins floating
					nxt_st.we    = 1'b0;
					nxt_st.sel   = 1'b0;
					nxt_st.phase = ST_WR_HOLD;
				end else begin
					nxt_st.step = st_ff.step - 1'b1;
				end
			end
			ST_WR_HOLD: begin
				// Data held one cycle past the write end for hold margin
				nxt_st.drive = 1'b0;
				nxt_st.phase = ST_IDLE;
			end
			default: begin
				// Unused codes fall back to idle
				nxt_st.phase = ST_IDLE;
			end
		endcase

		// Leaving retention restarts the recovery wait, aborting strobes
		if (RETENTION_EXIT_I) begin
			nxt_st.phase    = ST_POWER;
			nxt_st.wait_cnt = RET_LOAD;
			nxt_st.sel      = 1'b0;
			nxt_st.oe       = 1'b0;
			nxt_st.we       = 1'b0;
			nxt_st.drive    = 1'b0;
			// An aborted read gives no answer and keeps the last data
			nxt_st.rd_valid = 1'b0;
			nxt_st.rd_data  = st_ff.rd_data;
		end
	end

	// State register; reset starts the power-up wait
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			// Strobes off and pins released while reset holds
			st_ff          <= '0;
			st_ff.phase    <= ST_POWER;
			st_ff.wait_cnt <= PU_LOAD;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Pin drive; all three selects move together
	always_comb begin
		// Strobes are inversions of registered bits, so they never glitch
		MEM_O.chip_select_n_first  = ~st_ff.sel;
		MEM_O.chip_select_n_second = ~st_ff.sel;
		MEM_O.chip_select_n_third  = ~st_ff.sel;
		MEM_O.out_en_n             = ~st_ff.oe;
		MEM_O.write_en_n           = ~st_ff.we;
		// Lanes enabled only while selected
		MEM_O.byte_en_n            = st_ff.sel ? ~st_ff.req.lane_en : '1;
		// Address and write data keep the last request between accesses
		MEM_O.addr                 = st_ff.req.addr;
		MEM_O.data_pins_out        = st_ff.req.wdata;
		MEM_O.data_pins_oe         = {DATA_W{st_ff.drive}};
	end

	// Handshake outputs; ready drops at once when the supply leaves retention
	assign REQ_READY_O = (st_ff.phase == ST_IDLE) && !RETENTION_EXIT_I;
	assign MEM_READY_O = (st_ff.phase != ST_POWER);
	// Read answer straight from flip-flops
	assign RD_VALID_O  = st_ff.rd_valid;
	assign RD_DATA_O   = st_ff.rd_data;

endmodule : sram_ctl

// [src/sram_ctl_pkg.sv]
// Purpose: Shared constants and carriers for the static memory controller
// Assumes: 250 MHz system clock, memory of 512K words by 32 bits
// Notes:   Times kept in their own unit, cycle counts derived here
package sram_ctl_pkg;

	localparam int ADDR_W   = 19;
	localparam int DATA_W   = 32;
	localparam int LANES    = 4;
	localparam int CLK_MHZ  = 250;

	// Power-up wait, retention recovery and write timing
	localparam int POWER_UP_US        = 1000;
	localparam int RETENTION_RECOV_US = 100;
	localparam int WRITE_LOW_TO_FLOAT_PS  = 5000;
	localparam int WRITE_DATA_SETUP_PS    = 5500;
	localparam int CYCLE_PS           = 1000000 / CLK_MHZ;
	localparam int POWER_UP_CYC       = POWER_UP_US * CLK_MHZ;
	localparam int RETENTION_CYC      = RETENTION_RECOV_US * CLK_MHZ;
	// Write pulse rounds up, at least one cycle
	localparam int WRITE_PULSE_CYC    =
		(WRITE_LOW_TO_FLOAT_PS + WRITE_DATA_SETUP_PS + CYCLE_PS - 1) / CYCLE_PS;
	// Read strobe covers 10 ns access, rounded up
	localparam int READ_ACCESS_PS     = 10000;
	localparam int READ_CYC           = (READ_ACCESS_PS + CYCLE_PS - 1) / CYCLE_PS;

	localparam int WAIT_W = 20;
	localparam int STEP_W = 4;

	// Request from the user side
	typedef struct packed {
		logic                  write;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
		logic [LANES-1:0]      lane_en;
	} mem_req_t;

	// Pins toward the memory
	typedef struct packed {
		logic                  chip_select_n_first;
		logic                  chip_select_n_second;
		logic                  chip_select_n_third;
		logic                  out_en_n;
		logic                  write_en_n;
		logic [LANES-1:0]      byte_en_n;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     data_pins_out;
		logic [DATA_W-1:0]     data_pins_oe;
	} mem_pins_t;

endpackage : sram_ctl_pkg
